/* File: logic/wwd_pkg.sv */
// Package for the windowed watchdog: register map, field layouts, reset values, timing.
// Assumes a 125 MHz APB clock and a low-speed count clock derived from it by a divider.
package wwd_pkg;

    // Clock rates in kHz, as used to derive the low-speed tick divider
    localparam int unsigned PCLK_FREQ_KHZ = 125000;
    localparam int unsigned LS_FREQ_KHZ   = 264;
    // Longest period rounds down, never below one cycle
    localparam int unsigned LS_DIV_CYCLES =
        (PCLK_FREQ_KHZ / LS_FREQ_KHZ) < 1 ? 1 : (PCLK_FREQ_KHZ / LS_FREQ_KHZ);

    // Register byte offsets
    localparam logic [11:0] OFS_RESTART = 12'h000;
    localparam logic [11:0] OFS_OSC_MODE = 12'h004;
    localparam logic [11:0] OFS_COUNT   = 12'h008;
    localparam logic [11:0] OFS_IRQ_STS = 12'h00c;
    localparam logic [11:0] OFS_IRQ_MSK = 12'h010;
    localparam logic [11:0] OFS_OPTION  = 12'h080;

    // Restart code
    localparam logic [7:0] RESTART_CODE = 8'hac;

    // Option byte field positions
    localparam int unsigned OPT_LOCK_BIT = 0;
    localparam int unsigned OPT_SEL_LSB  = 1;
    localparam int unsigned OPT_WIN_LSB  = 4;
    // Oscillator mode register: stop bit position
    localparam int unsigned OSC_STOP_BIT = 1;

    // Reset values
    localparam logic [7:0] OPTION_RST = 8'h00;
    localparam logic       STOP_RST   = 1'b0;
    localparam logic [2:0] IRQ_RST    = 3'h0;

    // Event bits in the interrupt status and mask
    localparam int unsigned EV_OVERFLOW = 0;
    localparam int unsigned EV_CLOSED   = 1;
    localparam int unsigned EV_BADCODE  = 2;
    localparam int unsigned EV_COUNT    = 3;

    // Counter geometry: overflow after 2^(MIN_EXP + select)
    localparam int unsigned MIN_EXP = 10;
    localparam int unsigned CNT_W   = 18;

    // Option byte carrier
    typedef struct packed {
        logic [1:0] open_period_size;
        logic [2:0] overflow_time_select;
        logic       lowspeed_osc_lock_option;
    } wwd_opt_t;

endpackage

/* File: logic/wwd_tick_div.sv */
// Divider producing a one-cycle enable at the low-speed count rate.
// Assumes a single free-running clock; the enable never gates a clock.
`timescale 1ns/1ps
module wwd_tick_div #(
    parameter int unsigned DIV = 473
) (
    input  wire logic pclk,
    input  wire logic presetn,
    output logic      tick
);
    localparam int unsigned DW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [DW-1:0] LAST = DW'(DIV - 1);

    logic [DW-1:0] cnt_reg;
    logic [DW-1:0] cnt_next;
    logic          tick_reg;

    // Wrap at the last count
    assign cnt_next = (cnt_reg == LAST) ? '0 : cnt_reg + DW'(1);
    assign tick     = tick_reg;

    // Free running; tick registered to keep it glitch free
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg  <= '0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            tick_reg <= (cnt_reg == LAST);
        end
    end
endmodule

/* File: logic/wwd_core.sv */
// Windowed watchdog with APB register access, sticky event interrupt and reset request.
// Assumes halt/stop/self-programming indications come from logic on pclk.
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps

module wwd_core
    import wwd_pkg::*;
#(
    parameter int unsigned LS_DIV = LS_DIV_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        halt_mode,
    input  wire logic        stop_mode,
    input  wire logic        self_prog_active,
    output logic             reset_req,
    output logic             irq
);

    // Register state
    wwd_opt_t              option_reg;
    logic                  osc_stop_reg;
    logic [EV_COUNT-1:0]   irq_sts_reg;
    logic [EV_COUNT-1:0]   irq_sts_next;
    logic [EV_COUNT-1:0]   irq_msk_reg;
    logic [CNT_W-1:0]      count_reg;
    logic [CNT_W-1:0]      count_next;
    logic                  reset_req_reg;
    logic [31:0]           prdata_reg;

    // Bus decode
    wire setup_phase = psel & ~penable;
    wire access      = psel & penable;
    wire wr_access   = access & pwrite;
    wire hit_restart = (paddr == OFS_RESTART);
    wire hit_osc     = (paddr == OFS_OSC_MODE);
    wire hit_count   = (paddr == OFS_COUNT);
    wire hit_sts     = (paddr == OFS_IRQ_STS);
    wire hit_msk     = (paddr == OFS_IRQ_MSK);
    wire hit_option  = (paddr == OFS_OPTION);
    wire mapped      = hit_restart | hit_osc | hit_count | hit_sts | hit_msk | hit_option;

    // Zero wait states; unmapped addresses answer with an error
    assign pready  = access;
    assign pslverr = access & ~mapped;
    assign prdata  = prdata_reg;

    // Low-speed count enable
    logic ls_tick;

    wwd_tick_div #(
        .DIV (LS_DIV)
    ) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (ls_tick)
    );

    // Overflow limit and window bound from the option byte
    wire [CNT_W-1:0] ovf_limit =
        CNT_W'(1) << (MIN_EXP + 32'(option_reg.overflow_time_select));
    wire [CNT_W-1:0] quarter   = ovf_limit >> 2;
    // Window size 00/01/10/11 opens the last 25/50/75/100 percent of the period
    wire [1:0]       closed_q  = 2'd3 - option_reg.open_period_size;
    wire [CNT_W-1:0] open_from = CNT_W'(quarter * closed_q);
    wire             win_open  = (count_reg >= open_from);

    // Freeze conditions only bite when the oscillator is not locked
    wire unlocked   = ~option_reg.lowspeed_osc_lock_option;
    wire low_power  = halt_mode | stop_mode;
    wire frozen     = unlocked & (low_power | osc_stop_reg);
    // Self-programming deliberately has no say here, the count keeps going
    wire run        = ls_tick & ~frozen;
    wire overflow   = run & (count_reg == ovf_limit - CNT_W'(1));

    // Restart register writes
    wire wr_restart = wr_access & hit_restart;
    wire good_code  = (pwdata[7:0] == RESTART_CODE);
    wire restart_ok = wr_restart & good_code & win_open;
    wire bad_code   = wr_restart & ~good_code;
    wire bad_window = wr_restart & good_code & ~win_open;

    // Counter: restart clears, freeze holds without clearing
    always_comb begin
        count_next = count_reg;
        if (restart_ok) begin
            count_next = '0;
        end else if (run) begin
            count_next = count_reg + CNT_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    // Reset request holds until the system reset takes the block down
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_req_reg <= 1'b0;
        end else if (overflow | bad_code | bad_window) begin
            reset_req_reg <= 1'b1;
        end
    end
    assign reset_req = reset_req_reg;

    // Sticky events: a new event beats a same-cycle clear
    wire [EV_COUNT-1:0] ev_set = {bad_code, bad_window, overflow};
    wire [EV_COUNT-1:0] ev_clr = (wr_access & hit_sts) ? pwdata[EV_COUNT-1:0] : '0;
    assign irq_sts_next = (irq_sts_reg & ~ev_clr) | ev_set;
    assign irq          = |(irq_sts_reg & irq_msk_reg);

    // Configuration and interrupt registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            option_reg   <= wwd_opt_t'(OPTION_RST[5:0]);
            osc_stop_reg <= STOP_RST;
            irq_sts_reg  <= IRQ_RST;
            irq_msk_reg  <= IRQ_RST;
        end else begin
            irq_sts_reg <= irq_sts_next;
            if (wr_access & hit_option) begin
                option_reg <= wwd_opt_t'(pwdata[5:0]);
            end
            if (wr_access & hit_osc) begin
                osc_stop_reg <= pwdata[OSC_STOP_BIT];
            end
            if (wr_access & hit_msk) begin
                irq_msk_reg <= pwdata[EV_COUNT-1:0];
            end
        end
    end

    // Read mux, sampled in the setup phase so read data comes from a flop
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (1'b1)
            hit_osc:    rd_mux = {30'h0, osc_stop_reg, 1'b0};
            hit_count:  rd_mux = {13'h0, win_open, count_reg};
            hit_sts:    rd_mux = {29'h0, irq_sts_reg};
            hit_msk:    rd_mux = {29'h0, irq_msk_reg};
            hit_option: rd_mux = {26'h0, option_reg};
            default:    rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup_phase & ~pwrite) begin
            prdata_reg <= rd_mux;
        end
    end

    // Self-programming input is observed only to document that it has no effect
    wire unused_ok = self_prog_active;

endmodule

/* File: bench/wwd_sva.sv */
// Port checker for the windowed watchdog core.
// Assumes it is bound onto every wwd_core instance.
`timescale 1ns/1ps
module wwd_sva
    import wwd_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        reset_req
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Decode of access phase and address map
    wire acc    = psel && penable;
    wire mapped = paddr inside {OFS_RESTART, OFS_OSC_MODE, OFS_COUNT,
                                OFS_IRQ_STS, OFS_IRQ_MSK, OFS_OPTION};
    sequence s_bad_write;
        acc && pwrite && paddr == OFS_RESTART && pwdata[7:0] != RESTART_CODE;
    endsequence
    sequence s_restart_read;
        psel && !penable && !pwrite && paddr == OFS_RESTART ##1 acc;
    endsequence
    a_zero_wait: assert property (acc |-> pready) else $error("pready late");
    a_unmapped_err: assert property (acc && !mapped |-> pslverr) else $error("no error");
    a_mapped_ok: assert property (acc && mapped |-> !pslverr) else $error("bad error");
    a_idle_quiet: assert property (!acc |-> !pslverr && !pready) else $error("idle bus");
    a_bad_code: assert property (s_bad_write |=> reset_req) else $error("no reset");
    a_reset_sticky: assert property (reset_req |=> reset_req) else $error("reset fell");
    a_restart_zero: assert property (s_restart_read |-> prdata == 32'h0) else $error("read");
    // Read data may only move when a read setup is seen
    a_read_holds: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("prdata moved");
endmodule
bind wwd_core wwd_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
                             .pready, .prdata, .pslverr, .reset_req);

/* File: bench/wwd_core_bench.sv */
// Bench for the watchdog core: APB accesses, low-power inputs, overflow timing.
// Assumes LS_DIV of 2 so the overflow counts stay short.
`timescale 1ns/1ps
module wwd_core_bench;
    import wwd_pkg::*;
    localparam int DIV = 2;
    logic        pclk = 0;
    logic        presetn = 0;
    logic        psel, penable, pwrite, halt_mode, stop_mode, self_prog_active;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, reset_req, irq, err;
    logic [17:0] c0;
    int          mismatches = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          t;
    wwd_core #(.LS_DIV(DIV)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .prdata, .pslverr, .halt_mode, .stop_mode, .self_prog_active,
        .reset_req, .irq);
    always #4 pclk = ~pclk;
    // Hang guard, well above the longest overflow run
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 40000) begin
            mismatches++;
            end_of_test();
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; waits for pready, the timeout ends a hang
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task rst;
        presetn <= 0;
        repeat (20) @(posedge pclk);
        presetn <= 1;
    endtask
    task end_of_test;
        $display("Mismatches %0d in %0d checks", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        {psel, penable, pwrite, halt_mode, stop_mode, self_prog_active} = '0;
        paddr = '0;
        pwdata = '0;
        rst();
        apb(0, OFS_OPTION, 0);
        chk(rd, {24'h0, OPTION_RST});
        apb(0, 12'h040, 0);
        chk({err, rd[30:0]}, 32'h80000000);
        // Overflow time for select codes 0 to 2, lock on, window always open
        for (int s = 0; s < 3; s++) begin
            rst();
            apb(1, OFS_OPTION, 32'h31 | (s << 1));
            t = 0;
            // Polled off the launching edge so the request has settled
            while (reset_req !== 1'b1 && t < 9000) begin
                @(negedge pclk);
                t++;
            end
            chk(t > (DIV << (10 + s)) - 20 && t <= (DIV << (10 + s)) + 2, 1);
            apb(0, OFS_IRQ_STS, 0);
            chk(rd, 1);
        end
        // Freeze causes with lock off; last pass has lock on and self-programming
        rst();
        apb(1, OFS_OPTION, 32'h34);
        for (int i = 0; i < 4; i++) begin
            halt_mode <= (i == 0) || (i == 3);
            stop_mode <= (i == 1) || (i == 3);
            self_prog_active <= (i == 3);
            apb(1, OFS_OSC_MODE, (i >= 2) ? 2 : 0);
            if (i == 3) apb(1, OFS_OPTION, 32'h35);
            apb(0, OFS_COUNT, 0);
            c0 = rd[17:0];
            repeat (20) @(posedge pclk);
            apb(0, OFS_COUNT, 0);
            chk(rd[17:0] == c0, i < 3);
        end
        apb(1, OFS_OPTION, 32'h34);
        apb(0, OFS_COUNT, 0);
        c0 = rd[17:0];
        halt_mode <= 0;
        stop_mode <= 0;
        apb(1, OFS_OSC_MODE, 0);
        // Let at least two low-speed ticks pass before looking
        repeat (4) @(posedge pclk);
        apb(0, OFS_COUNT, 0);
        chk(rd[17:0] > c0 && rd[17:0] < c0 + 40, 1);
        apb(1, OFS_RESTART, RESTART_CODE);
        apb(0, OFS_COUNT, 0);
        chk(rd[17:0] < 4, 1);
        apb(0, OFS_RESTART, 0);
        chk(rd, 0);
        chk(reset_req, 0);
        // Closed-window restart, then a wrong code; event, mask and clear
        for (int k = 0; k < 2; k++) begin
            rst();
            apb(1, OFS_OPTION, k ? 32'h32 : 32'h02);
            apb(1, OFS_RESTART, k ? 32'h55 : RESTART_CODE);
            apb(0, OFS_IRQ_STS, 0);
            chk(rd, k ? 4 : 2);
            chk(reset_req, 1);
            chk(irq, 0);
            apb(1, OFS_IRQ_MSK, k ? 4 : 2);
            @(negedge pclk);
            chk(irq, 1);
            apb(1, OFS_IRQ_STS, k ? 4 : 2);
            @(negedge pclk);
            chk(irq, 0);
        end
        // Partial windows: restart accepted once the open part is reached
        for (int w = 1; w < 3; w++) begin
            rst();
            apb(1, OFS_OPTION, 32'h02 | (w << 4));
            repeat ((3 - w) * 512 * DIV + 40) @(posedge pclk);
            apb(0, OFS_COUNT, 0);
            chk(rd[18], 1);
            apb(1, OFS_RESTART, RESTART_CODE);
            apb(0, OFS_COUNT, 0);
            chk(rd[17:0] < 4, 1);
            chk(reset_req, 0);
        end
        end_of_test();
    end
endmodule
